// ---- design/scc_regs.vh ----
// register map, field positions, reset values and counts for the sleep and clock controller
// assumes a 32-bit apb slave with word-aligned registers
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
`define SCC_ADDR_W 12
`define SCC_CLKSEL_OFS 12'h000
`define SCC_PLLCTRL_OFS 12'h004
`define SCC_PSCTRL_OFS 12'h008
`define SCC_OSCCTRL_OFS 12'h00c
`define SCC_SLEEPCTRL_OFS 12'h010
`define SCC_PRR_OFS 12'h014
`define SCC_STATUS_OFS 12'h018
`define SCC_WAKEEN_OFS 12'h01c
// clock source codes
`define SCC_SRC_RC2M 3'h0
`define SCC_SRC_RC32M 3'h1
`define SCC_SRC_RC32K 3'h2
`define SCC_SRC_XOSC 3'h3
`define SCC_SRC_PLL 3'h4
`define SCC_SRC_TOSC 3'h5
`define SCC_SRC_EXT 3'h6
// sleep mode codes
`define SCC_SM_IDLE 3'h0
`define SCC_SM_PDOWN 3'h2
`define SCC_SM_PSAVE 3'h3
`define SCC_SM_STDBY 3'h6
`define SCC_SM_ESTDBY 3'h7
// field positions
`define SCC_PLL_FAC_LSB 0
`define SCC_PLL_SRC_LSB 8
`define SCC_PS_A_LSB 0
`define SCC_PS_BC_LSB 4
`define SCC_OSC_CFD_BIT 8
`define SCC_OSC_DFLL2_BIT 9
`define SCC_OSC_DFLL32_BIT 10
`define SCC_OSC_CALREF_BIT 11
`define SCC_OSC_RTCSRC_LSB 12
// reset values
`define SCC_PLL_FAC_RST 5'h02
`define SCC_OSC_EN_RST 8'h01
`define SCC_PRR_RST 8'h00
`define SCC_WAKE_RST 4'h0
// a switch waits this many new-clock edges before release
`define SCC_SYNC_STAGES 2
`endif

// ---- design/scc_sleep_clock.v ----
// sleep and clock controller: source select, safe switch, pll/prescale setup,
// oscillator failure fallback, calibration select, sleep modes and gating.
// assumes the oscillators arrive as enable-style clock ticks synchronous to pclk
// and that the cpu raises sleep_req while it executes a sleep instruction.
//
// Overview of operation
// - reset selects the 2 MHz internal oscillator
// - software may change source while running
// - switching never makes runt pulses
// - oscillator failure gives nmi and fallback
// - 32 kHz watchdog oscillator never system clock
// - watchdog oscillator feeds wdt, bod, rtc
// - 32.768 kHz rc for system or rtc
// - pll factor programmable from 2 to 31
// - prescaler ratios from 1 up to 2048
// - fast clocks at two and four times
// - calibration reference is rc32k or crystal
// - five sleep modes, entered from active only
// - enabled interrupts and resets wake device
// - power reduction stops and freezes peripheral
// - idle stops cpu and nvm only
// - power-down stops all clock sources; the watchdog oscillator stays on
// - power-down wakes on twi and pin change
// - power-save keeps rtc and its wake
// - standby keeps sources, gates cpu, peripherals, rtc
// - extended standby keeps sources and rtc
//
// Chosen here: register access over APB and the address map.
`include "scc_regs.vh"
module scc_sleep_clock (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // oscillator ticks, one per source code, bit 7 unused
  input wire [7:0] src_tick,
  input wire [7:0] src_ready,
  input wire xosc_fail,
  // cpu and wake sources
  input wire sleep_req,
  input wire irq_any,
  input wire irq_twi_addr,
  input wire irq_pin_async,
  input wire irq_rtc,
  input wire reset_src,
  // clock enables out
  output reg sys_clk_en,
  output reg cpu_clk_en,
  output reg nvm_clk_en,
  output reg per_clk_en,
  output reg per2x_clk_en,
  output reg per4x_clk_en,
  output reg rtc_clk_en,
  output reg [7:0] periph_clk_en,
  output reg [7:0] osc_enable,
  output reg wdt_bod_osc_en,
  output reg [1:0] rtc_src_sel,
  output reg dfll2m_en,
  output reg dfll32m_en,
  output reg cal_ref_sel,
  output reg [4:0] pll_factor,
  output reg [1:0] pll_src,
  output reg [3:0] ps_a,
  output reg [1:0] ps_bc,
  output reg nmi,
  output reg sleeping
);
  localparam ST_ACTIVE = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam SW_IDLE = 2'h0;
  localparam SW_WAIT = 2'h1;

  reg [2:0] clk_sel;
  reg [2:0] pending_sel;
  reg [1:0] sw_state;
  reg [1:0] sw_cnt;
  reg [15:0] osc_ctrl;
  reg [7:0] prr;
  reg [7:0] slp_ctrl;
  reg [3:0] wake_en;
  reg [1:0] pm_state;
  reg [2:0] cur_mode;
  reg cfd_flag;
  // wide enough for the 2048 ratio
  reg [10:0] ps_cnt;
  reg [1:0] fast_ph;
  wire wr = psel & penable & pwrite & ~pready;
  wire rd = psel & penable & ~pwrite & ~pready;
  wire [2:0] req_sel = pwdata[2:0];

  // legal system sources exclude the watchdog oscillator
  function legal_src;
    input [2:0] s;
    begin
      legal_src = (s <= `SCC_SRC_EXT);
    end
  endfunction

  function legal_mode;
    input [2:0] m;
    begin
      legal_mode = (m == `SCC_SM_IDLE) || (m == `SCC_SM_PDOWN) || (m == `SCC_SM_PSAVE) ||
        (m == `SCC_SM_STDBY) || (m == `SCC_SM_ESTDBY);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `SCC_WAKEEN_OFS);
    end
  endfunction

  // modes in which the rtc clock survives and may wake
  function rtc_mode;
    input [2:0] m;
    begin
      rtc_mode = (m == `SCC_SM_PSAVE) || (m == `SCC_SM_ESTDBY);
    end
  endfunction

  // modes in which the enabled sources keep running
  function src_mode;
    input [2:0] m;
    begin
      src_mode = (m == `SCC_SM_STDBY) || (m == `SCC_SM_ESTDBY);
    end
  endfunction

  // read view of one register word, unmapped words read zero
  function [31:0] reg_view;
    input [11:0] a;
    begin
      case (a)
        `SCC_CLKSEL_OFS: reg_view = {28'h0, sw_state == SW_WAIT, clk_sel};
        `SCC_PLLCTRL_OFS: reg_view = {22'h0, pll_src, 3'h0, pll_factor};
        `SCC_PSCTRL_OFS: reg_view = {26'h0, ps_bc, ps_a};
        `SCC_OSCCTRL_OFS: reg_view = {16'h0, osc_ctrl};
        `SCC_SLEEPCTRL_OFS: reg_view = {24'h0, slp_ctrl};
        `SCC_PRR_OFS: reg_view = {24'h0, prr};
        `SCC_STATUS_OFS: reg_view = {16'h0, src_ready, 5'h0, cfd_flag, sleeping, nmi};
        `SCC_WAKEEN_OFS: reg_view = {28'h0, wake_en};
        default: reg_view = 32'h0;
      endcase
    end
  endfunction

  // apb slave, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      // prdata holds between reads so a late sampler still sees it
      if (rd) begin
        prdata <= reg_view(paddr);
      end
    end
  end

  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_factor <= `SCC_PLL_FAC_RST;
      pll_src <= 2'h0;
      ps_a <= 4'h0;
      ps_bc <= 2'h0;
      osc_ctrl <= {8'h0, `SCC_OSC_EN_RST};
      slp_ctrl <= 8'h0;
      prr <= `SCC_PRR_RST;
      wake_en <= `SCC_WAKE_RST;
    end else if (wr) begin
      case (paddr)
        `SCC_PLLCTRL_OFS: begin
          // out-of-range factors are ignored, last legal one kept
          if (pwdata[4:0] >= 5'h02) pll_factor <= pwdata[4:0];
          pll_src <= pwdata[`SCC_PLL_SRC_LSB +: 2];
        end
        `SCC_PSCTRL_OFS: begin
          // a = 11 gives the 2048 ratio
          // out-of-range codes are dropped, the last legal ratio stays
          if (pwdata[3:0] <= 4'hb) ps_a <= pwdata[3:0];
          ps_bc <= pwdata[`SCC_PS_BC_LSB +: 2];
        end
        // bit 0 keeps rc2m on, it is the fallback source
        `SCC_OSCCTRL_OFS: osc_ctrl <= {pwdata[15:8], pwdata[7:1], 1'b1};
        `SCC_SLEEPCTRL_OFS: slp_ctrl <= pwdata[7:0];
        `SCC_PRR_OFS: prr <= pwdata[7:0];
        `SCC_WAKEEN_OFS: wake_en <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // a failure in the cycle of the clear wins, so no failure is lost
  wire fail_hit = osc_ctrl[`SCC_OSC_CFD_BIT] && xosc_fail && (clk_sel == `SCC_SRC_XOSC);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfd_flag <= 1'b0;
    end else if (fail_hit) begin
      cfd_flag <= 1'b1;
    end else if (wr && paddr == `SCC_STATUS_OFS && pwdata[2]) begin
      cfd_flag <= 1'b0;
    end
  end

  // clock switch: old source kept until new one is ready and has ticked twice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel <= `SCC_SRC_RC2M;
      pending_sel <= `SCC_SRC_RC2M;
      sw_state <= SW_IDLE;
      sw_cnt <= 2'h0;
      nmi <= 1'b0;
    end else begin
      nmi <= 1'b0;
      // fallback bypasses the handshake: a dead crystal gives no ticks to wait for
      if (fail_hit) begin
        clk_sel <= `SCC_SRC_RC2M;
        sw_state <= SW_IDLE;
        nmi <= 1'b1;
      end else begin
        case (sw_state)
          SW_IDLE: begin
            if (wr && paddr == `SCC_CLKSEL_OFS && legal_src(req_sel) && req_sel != clk_sel) begin
              pending_sel <= req_sel;
              sw_cnt <= 2'h0;
              sw_state <= SW_WAIT;
            end
          end
          SW_WAIT: begin
            if (src_ready[pending_sel] && src_tick[pending_sel]) begin
              if (sw_cnt == `SCC_SYNC_STAGES - 1) begin
                clk_sel <= pending_sel;
                sw_state <= SW_IDLE;
              end else begin
                sw_cnt <= sw_cnt + 2'h1;
              end
            end
          end
          default: sw_state <= SW_IDLE;
        endcase
      end
    end
  end

  // prescaler and fast clocks; a, then 4x/2x/1x phase
  wire src_tick_sel = src_tick[clk_sel];
  // eleven count bits reach the 2048 ratio at a = 11
  wire [11:0] ps_div = 12'h001 << ps_a;
  wire [10:0] ps_last = ps_div[10:0] - 11'h001;
  // >= so a ratio cut mid-count releases at once instead of wrapping
  wire ps_tick = src_tick_sel && ((ps_a == 4'h0) || (ps_cnt >= ps_last));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt <= 11'h000;
      fast_ph <= 2'h0;
    end else if (src_tick_sel) begin
      ps_cnt <= ps_tick ? 11'h000 : ps_cnt + 11'h001;
      if (ps_tick) fast_ph <= fast_ph + 2'h1;
    end
  end
  wire tick4 = ps_tick;
  wire tick2 = ps_tick && (ps_bc == 2'h0 || fast_ph[0]);
  wire tick1 = ps_tick && (ps_bc == 2'h0 || fast_ph == 2'h3);

  // sleep state
  // a wake needs one edge; the enables follow on the edge after
  // a reset source always wakes, whatever the mode
  wire wake_rst = reset_src;
  // idle keeps the interrupt controller, so any interrupt wakes
  wire wake_idle = (cur_mode == `SCC_SM_IDLE) && irq_any;
  // deep modes hear reset, the asynchronous wake sources and, in power-save and extended standby, the rtc
  wire wake_async = (irq_twi_addr && wake_en[0]) || (irq_pin_async && wake_en[1]);
  wire wake_rtc = rtc_mode(cur_mode) && irq_rtc && wake_en[2];
  wire wake = wake_rst || wake_idle || wake_async || wake_rtc;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_state <= ST_ACTIVE;
      cur_mode <= `SCC_SM_IDLE;
      sleeping <= 1'b0;
    end else begin
      case (pm_state)
        ST_ACTIVE: begin
          // only from active, only on request, only with sleep enabled
          if (sleep_req && slp_ctrl[0] && legal_mode(slp_ctrl[3:1])) begin
            cur_mode <= slp_ctrl[3:1];
            pm_state <= ST_SLEEP;
            sleeping <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            pm_state <= ST_ACTIVE;
            sleeping <= 1'b0;
          end
        end
        default: pm_state <= ST_ACTIVE;
      endcase
    end
  end

  wire in_sleep = (pm_state == ST_SLEEP);
  wire deep = in_sleep && cur_mode != `SCC_SM_IDLE;
  wire src_kept = src_mode(cur_mode);
  wire rtc_kept = rtc_mode(cur_mode);

  // one gate per peripheral; withheld ticks leave its state frozen
  wire per_tick = tick1 && !deep;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_per
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          periph_clk_en[gi] <= 1'b0;
        end else begin
          periph_clk_en[gi] <= per_tick && !prr[gi];
        end
      end
    end
  endgenerate

  // gated clock ticks, all registered so no glitch reaches a consumer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      nvm_clk_en <= 1'b0;
      per_clk_en <= 1'b0;
      per2x_clk_en <= 1'b0;
      per4x_clk_en <= 1'b0;
      rtc_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= tick1 && !deep;
      // idle stops only the cpu side; peripherals keep their ticks
      cpu_clk_en <= tick1 && !in_sleep;
      nvm_clk_en <= tick1 && !in_sleep;
      per_clk_en <= per_tick;
      per2x_clk_en <= tick2 && !deep;
      per4x_clk_en <= tick4 && !deep;
      rtc_clk_en <= !deep || rtc_kept;
    end
  end

  // oscillator and calibration controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= `SCC_OSC_EN_RST;
      wdt_bod_osc_en <= 1'b1;
      rtc_src_sel <= 2'h0;
      dfll2m_en <= 1'b0;
      dfll32m_en <= 1'b0;
      cal_ref_sel <= 1'b0;
    end else begin
      // deep modes stop sources unless standby keeps them
      // the running source stays on even if software cleared its enable
      osc_enable <= (deep && !src_kept) ? 8'h0 : (osc_ctrl[7:0] | (8'h01 << clk_sel));
      // the watchdog oscillator has no software control at all
      wdt_bod_osc_en <= 1'b1;
      rtc_src_sel <= osc_ctrl[`SCC_OSC_RTCSRC_LSB +: 2];
      // calibration loops would chase a stopped reference, so deep modes pause them
      dfll2m_en <= osc_ctrl[`SCC_OSC_DFLL2_BIT] && !deep;
      dfll32m_en <= osc_ctrl[`SCC_OSC_DFLL32_BIT] && !deep;
      cal_ref_sel <= osc_ctrl[`SCC_OSC_CALREF_BIT];
    end
  end
endmodule

// ---- dv/scc_osc_model.sv ----
// oscillator bank seen by the controller: ready and ticks per enabled source
// assumes osc_enable from the controller; the bench drives fail_cmd
module scc_osc_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire [7:0] osc_enable,
  input wire fail_cmd,
  // towards the controller
  output logic [7:0] src_tick,
  output logic [7:0] src_ready,
  output wire xosc_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  // a dead crystal only shows while it is enabled
  assign xosc_fail = fail_cmd & osc_enable[3];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'h0;
      src_tick <= 8'h00;
      src_ready <= 8'h00;
    end else begin
      ph <= ~ph;
      src_ready <= osc_enable;
      // a stopped source gives no ticks at all
      src_tick <= src_ready & {8{ph}};
    end
  end
endmodule

// ---- dv/scc_sleep_clock_chk.sv ----
// port assertions for the sleep and clock controller
// assumes one apb wait state and sleep timing as handed over
`include "scc_regs.vh"
module scc_sleep_clock_chk (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // sources and cpu
  input wire xosc_fail,
  input wire sleep_req,
  // outputs watched
  input wire sys_clk_en,
  input wire cpu_clk_en,
  input wire nvm_clk_en,
  input wire per_clk_en,
  input wire per2x_clk_en,
  input wire per4x_clk_en,
  input wire rtc_clk_en,
  input wire wdt_bod_osc_en,
  input wire [4:0] pll_factor,
  input wire [3:0] ps_a,
  input wire nmi,
  input wire sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mode;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the mode field, taken where the write lands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == `SCC_SLEEPCTRL_OFS)
      mode <= pwdata[3:1];
  end
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
  AST_WDT_OSC: assert property (wdt_bod_osc_en)
    else $error("watchdog oscillator off");
  AST_PLL_RANGE: assert property (pll_factor >= 5'h02)
    else $error("pll factor below two");
  AST_PS_RANGE: assert property (ps_a <= 4'hb)
    else $error("prescaler field out of range");
  AST_FAST_PHASE: assert property (per_clk_en |-> per2x_clk_en && per4x_clk_en)
    else $error("fast clocks out of phase");
  AST_NMI_PULSE: assert property (nmi |-> $past(xosc_fail) ##1 !nmi)
    else $error("nmi without failure or too long");
  AST_SLEEP_REQ: assert property ($rose(sleeping) |-> $past(sleep_req))
    else $error("sleep without cpu request");
  AST_IDLE_CPU: assert property (sleeping && $past(sleeping) |-> !cpu_clk_en && !nvm_clk_en)
    else $error("cpu or nvm clock runs in sleep");
  AST_DEEP_PER: assert property (sleeping && $past(sleeping) && mode != `SCC_SM_IDLE |-> !per_clk_en)
    else $error("peripheral clock runs in deep sleep");
  AST_DEEP_RTC: assert property (sleeping && $past(sleeping) && mode inside {`SCC_SM_PDOWN, `SCC_SM_STDBY}
    |-> !rtc_clk_en)
    else $error("rtc clock runs where it must stop");
  AST_PDOWN_SYS: assert property (sleeping && $past(sleeping) && mode == `SCC_SM_PDOWN |-> !sys_clk_en)
    else $error("system clock runs in power-down");
  cover property ($rose(sleeping));
  cover property (nmi);
  cover property (pready && pslverr);
  cover property (sleeping && mode == `SCC_SM_ESTDBY);
endmodule
bind scc_sleep_clock scc_sleep_clock_chk scc_sleep_clock_chk_i (.*);

// ---- dv/sleep_and_clock_control_test.sv ----
// self-checking bench for the sleep and clock controller
// assumes the oscillator model answers enables; the apb master lives here
`include "scc_regs.vh"
`define CK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module sleep_and_clock_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, sleep_req, fail_cmd, err;
  logic irq_any, irq_twi_addr, irq_pin_async, irq_rtc, reset_src;
  logic pready, pslverr, xosc_fail, nmi, sleeping, per_clk_en, cal_ref_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] src_tick, src_ready, periph_clk_en, osc_enable;
  logic [4:0] pll_factor;
  logic [3:0] ps_a;
  logic [1:0] rtc_src_sel, pll_src;
  int n_errors = 0, checks_done = 0, cyc = 0;
  scc_sleep_clock scc_sleep_clock_i (.*, .sys_clk_en(), .cpu_clk_en(), .nvm_clk_en(), .per2x_clk_en(),
    .per4x_clk_en(), .rtc_clk_en(), .wdt_bod_osc_en(), .dfll2m_en(), .dfll32m_en(), .ps_bc());
  scc_osc_model scc_osc_model_i (.*);
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic sw(input logic [2:0] s);
    apb(1'h1, `SCC_CLKSEL_OFS, {29'h0, s});
    rd = '1;
    repeat (20) if (rd[3:0] !== {1'h0, s}) apb(1'h0, `SCC_CLKSEL_OFS, 32'h0);
    `CK("sel", {1'h0, s}, rd[3:0])
  endtask
  task automatic nap();
    sleep_req <= 1'h1;
    @(posedge pclk);
    sleep_req <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset();
    `CK("pll_rst", 5'h02, pll_factor)
    `CK("osc_rst", 8'h01, osc_enable)
    apb(1'h0, `SCC_CLKSEL_OFS, 32'h0);
    `CK("src_rst", 4'h0, rd[3:0])
    apb(1'h0, 12'h020, 32'h0);
    `CK("unmapped", 1'h1, err)
  endtask
  task automatic t_cfg();
    apb(1'h1, `SCC_PLLCTRL_OFS, 32'h1f);
    `CK("pll_max", 5'h1f, pll_factor)
    apb(1'h1, `SCC_PLLCTRL_OFS, 32'h01);
    `CK("pll_low", 5'h1f, pll_factor)
    apb(1'h1, `SCC_PLLCTRL_OFS, 32'h302);
    `CK("pll_min", 5'h02, pll_factor)
    `CK("pll_src", 2'h3, pll_src)
    apb(1'h1, `SCC_PSCTRL_OFS, 32'h0b);
    `CK("ps_max", 4'hb, ps_a)
    apb(1'h1, `SCC_PSCTRL_OFS, 32'h0c);
    `CK("ps_over", 4'hb, ps_a)
    apb(1'h1, `SCC_PSCTRL_OFS, 32'h00);
  endtask
  task automatic t_switch();
    apb(1'h1, `SCC_OSCCTRL_OFS, 32'h2807);
    `CK("rtc_src", 2'h2, rtc_src_sel)
    `CK("cal_ref", 1'h1, cal_ref_sel)
    sw(`SCC_SRC_RC32K);
    sw(`SCC_SRC_RC32M);
    apb(1'h1, `SCC_CLKSEL_OFS, 32'h7);
    apb(1'h0, `SCC_CLKSEL_OFS, 32'h0);
    `CK("bad_src", 4'h1, rd[3:0])
  endtask
  task automatic t_fail();
    logic seen;
    seen = 1'h0;
    apb(1'h1, `SCC_OSCCTRL_OFS, 32'h290f);
    sw(`SCC_SRC_XOSC);
    fail_cmd <= 1'h1;
    repeat (20) @(posedge pclk) seen |= nmi;
    fail_cmd <= 1'h0;
    `CK("nmi", 1'h1, seen)
    apb(1'h0, `SCC_CLKSEL_OFS, 32'h0);
    `CK("fallback", 1'h0, rd[2:0] == `SCC_SRC_XOSC)
    apb(1'h0, `SCC_STATUS_OFS, 32'h0);
    `CK("fail_flag", 1'h1, rd[2])
    apb(1'h1, `SCC_STATUS_OFS, 32'h4);
    apb(1'h0, `SCC_STATUS_OFS, 32'h0);
    `CK("flag_clr", 1'h0, rd[2])
  endtask
  task automatic t_prr();
    logic [7:0] seen;
    seen = 8'h00;
    apb(1'h1, `SCC_PRR_OFS, 32'hfe);
    repeat (12) @(posedge pclk) seen |= periph_clk_en;
    `CK("prr_gate", 8'h01, seen)
    apb(1'h1, `SCC_PRR_OFS, 32'h0);
  endtask
  task automatic t_sleep(input logic [2:0] m, input logic [3:0] k);
    logic [7:0] keep;
    logic run;
    keep = osc_enable;
    run = 1'h0;
    apb(1'h1, `SCC_SLEEPCTRL_OFS, {28'h0, m, 1'h1});
    nap();
    `CK("asleep", 1'h1, sleeping)
    repeat (8) @(posedge pclk) run |= per_clk_en;
    `CK("per_run", m == `SCC_SM_IDLE, run)
    if (m[2]) `CK("osc_kept", keep, osc_enable)
    if (m != `SCC_SM_IDLE) begin
      irq_rtc <= 1'h1;
      repeat (3) @(posedge pclk);
      `CK("rtc_wake", m == `SCC_SM_PDOWN || m == `SCC_SM_STDBY, sleeping)
      irq_rtc <= 1'h0;
    end
    {reset_src, irq_pin_async, irq_twi_addr, irq_any} <= k;
    repeat (3) @(posedge pclk);
    `CK("woken", 1'h0, sleeping)
    {reset_src, irq_pin_async, irq_twi_addr, irq_any} <= 4'h0;
    @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, fail_cmd} <= '0;
    {irq_any, irq_twi_addr, irq_pin_async, irq_rtc, reset_src} <= '0;
    paddr <= '0;
    pwdata <= '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_cfg();
    t_switch();
    t_fail();
    t_prr();
    apb(1'h1, `SCC_WAKEEN_OFS, 32'h7);
    apb(1'h1, `SCC_SLEEPCTRL_OFS, 32'h4);
    nap();
    `CK("no_sleep", 1'h0, sleeping)
    t_sleep(`SCC_SM_IDLE, 4'h1);
    t_sleep(`SCC_SM_PDOWN, 4'h2);
    t_sleep(`SCC_SM_PSAVE, 4'h4);
    t_sleep(`SCC_SM_STDBY, 4'h8);
    t_sleep(`SCC_SM_ESTDBY, 4'h2);
    close_out();
  end
endmodule
